// ---- src/link_fault_encoder.sv ----
// Fault status encoder for the serial link master with APB registers.
// Assumes synchronous fault inputs and a single 100 MHz clock pclk.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R01] Fault shown as class byte then detail byte, both 8 bits.
// [R02] Class bit 0 set when master receives invalid link data.
// [R03] Class bit 1 set when a slave station reports an error.
// [R04] Class flags are independent and may be set together.
// [R05] With slave error, detail bits 0-4 hold slave group plus one.
// [R06] Detail bit 5 set when the slave saw invalid data.
// [R07] Detail bit 6 set for other slave errors.
// [R08] Detail bit 7 set for slave watchdog or parity error.
// [R09] Class bit 2 set when the link to a slave is dropped.
// [R10] Class bit 3 or 4 set on internal controller parity error; the code only ever sets bit 3.
// [R11] Controller watchdog fault raises alarm 951.
// [R12] Option board error raises alarm 972 with slot and board code.
// [R13] Failed backplane transfer to option board raises alarm 974.
// [R14] Failed transfer to the sequence controller also raises 974.
// [R15] Bus error inside the main processor board raises alarm 975.
// [R16] Outputs go out and inputs come back at fixed intervals.
// [R17] Status bytes reset to zero and hold until acknowledged.
module link_fault_encoder
  import fault_status_pkg::*;
#(
  parameter int PERIOD = fault_status_pkg::LINK_PERIOD_CYC,
  parameter int SLOT_W = 4
) (
  input wire logic pclk, // APB clock.
  input wire logic presetn, // Async active-low reset.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic master_bad_data, // Master got invalid data.
  input wire logic slave_err, // A slave reported an error.
  input wire logic [4:0] slave_group, // Group of faulting slave.
  input wire fault_status_pkg::slave_fault_t slave_kind, // Slave fault kind.
  input wire logic link_drop, // Link to a slave dropped.
  input wire logic ctl_parity_err, // Controller parity error.
  input wire logic ctl_wdog_err, // Controller watchdog fault.
  input wire logic option_err, // Option board error.
  input wire logic [SLOT_W-1:0] option_slot, // Slot of that board.
  input wire logic [9:0] option_code, // Board's own alarm code.
  input wire logic fbus_opt_err, // Backplane transfer failed.
  input wire logic fbus_ctl_err, // Transfer to controller failed.
  input wire logic local_bus_err, // Bus error inside main board.
  output logic exchange_tick, // Fixed-interval exchange strobe.
  output logic [7:0] class_byte, // Class status byte.
  output logic [7:0] detail_byte, // Detail status byte.
  output logic [9:0] alarm_code, // Latched system alarm code.
  output logic [SLOT_W-1:0] alarm_slot, // Slot for alarm 972.
  output logic [9:0] alarm_sub_code, // Board code for alarm 972.
  output logic irq // Level interrupt.
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ALARM
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic [7:0] cls;
    logic [7:0] det;
    logic [9:0] code;
    logic [SLOT_W-1:0] slot;
    logic [9:0] sub;
    logic [IRQ_W-1:0] ista;
    logic [IRQ_W-1:0] imask;
    logic run;
    logic [31:0] rdata;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic tick;
  logic wr_en;
  logic rd_en;
  logic [IRQ_W-1:0] ev;
  logic link_ev;

  // Returns the detail byte for one slave report.
  function automatic logic [7:0] detail_of(input logic [4:0] grp,
                                           input slave_fault_t kind);
    logic [7:0] d;
    d = 8'h00;
    d[DET_GROUP_LSB +: DET_GROUP_W] = grp + 5'h01; // see [R05]
    case (kind)
      SLV_BAD_DATA: d[DET_BAD_DATA] = 1'b1; // see [R06]
      SLV_OTHER: d[DET_OTHER] = 1'b1; // see [R07]
      SLV_WDOG, SLV_PARITY: d[DET_WDOG_PAR] = 1'b1; // see [R08]
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  // Returns true when an access hits the given address.
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction

  // Paces the periodic output and input exchanges.
  link_exchange_timer #(
    .PERIOD(PERIOD)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(st_r.run),
    .tick(tick) // see [R16]
  );

  // Bus strobes; every access completes in its first access cycle.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // Link faults are only sampled on the exchange strobe.
  assign link_ev = tick && (master_bad_data || slave_err ||
                            link_drop || ctl_parity_err);

  // Event vector for the interrupt status register.
  always_comb begin
    ev = '0;
    ev[IRQ_LINK] = link_ev;
    ev[IRQ_WDOG] = ctl_wdog_err;
    ev[IRQ_OPTION] = option_err;
    ev[IRQ_FBUS] = fbus_opt_err || fbus_ctl_err;
    ev[IRQ_LOCAL] = local_bus_err;
  end

  // Next-state logic: capture, alarm priority, register writes.
  always_comb begin
    st_nxt = st_r;
    // Capture link fault bytes while no alarm is held.
    if (st_r.mode == ST_IDLE && link_ev) begin
      st_nxt.cls = 8'h00;
      st_nxt.cls[CLS_MASTER_BAD] = master_bad_data; // see [R02] [R04]
      st_nxt.cls[CLS_SLAVE_ERR] = slave_err; // see [R03] [R04]
      st_nxt.cls[CLS_LINK_DROP] = link_drop; // see [R09]
      st_nxt.cls[CLS_PARITY_A] = ctl_parity_err; // see [R10]
      st_nxt.det = slave_err ? detail_of(slave_group, slave_kind)
                             : 8'h00; // see [R01]
      st_nxt.code = ALM_LINK;
      st_nxt.mode = ST_ALARM;
    end
    // System alarms, most severe first; only latched when idle.
    if (st_r.mode == ST_IDLE) begin
      if (ctl_wdog_err) begin
        st_nxt.code = ALM_WDOG; // see [R11]
        st_nxt.mode = ST_ALARM;
      end else if (option_err) begin
        st_nxt.code = ALM_OPTION; // see [R12]
        st_nxt.slot = option_slot;
        st_nxt.sub = option_code;
        st_nxt.mode = ST_ALARM;
      end else if (fbus_opt_err || fbus_ctl_err) begin
        st_nxt.code = ALM_FBUS; // see [R13] [R14]
        st_nxt.mode = ST_ALARM;
      end else if (local_bus_err) begin
        st_nxt.code = ALM_LOCAL; // see [R15]
        st_nxt.mode = ST_ALARM;
      end
    end
    // Register writes.
    if (wr_en) begin
      if (hit(paddr, ADDR_STATUS) && st_r.mode == ST_ALARM && pwdata[0]) begin
        // Acknowledge releases the held alarm.
        st_nxt.cls = BYTE_RST; // see [R17]
        st_nxt.det = BYTE_RST;
        st_nxt.code = ALM_NONE;
        st_nxt.slot = '0;
        st_nxt.sub = '0;
        st_nxt.mode = ST_IDLE;
      end
      if (hit(paddr, ADDR_IRQ_STAT)) begin
        st_nxt.ista = st_r.ista & ~pwdata[IRQ_W-1:0];
      end
      if (hit(paddr, ADDR_IRQ_MASK)) begin
        st_nxt.imask = pwdata[IRQ_W-1:0];
      end
      if (hit(paddr, ADDR_CTRL)) begin
        st_nxt.run = pwdata[0];
      end
    end
    // New events win over a simultaneous clear.
    st_nxt.ista = st_nxt.ista | ev;
    // Read data is captured in the setup cycle.
    if (rd_en) begin
      st_nxt.rdata = 32'h0000_0000;
      case (paddr)
        ADDR_STATUS: st_nxt.rdata = {16'h0000, st_r.cls, st_r.det};
        ADDR_ALARM: st_nxt.rdata = {21'h0, st_r.mode == ST_ALARM,
                                    st_r.code};
        ADDR_IRQ_STAT: st_nxt.rdata = 32'(st_r.ista);
        ADDR_IRQ_MASK: st_nxt.rdata = 32'(st_r.imask);
        ADDR_CTRL: st_nxt.rdata = {31'h0, st_r.run};
        ADDR_SLOT: st_nxt.rdata = {12'h000, st_r.sub, 6'h00,
                                   4'(st_r.slot)};
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '{mode: ST_IDLE, cls: BYTE_RST, det: BYTE_RST,
                code: ALM_NONE, slot: '0, sub: '0, ista: '0,
                imask: MASK_RST, run: 1'b1, rdata: 32'h0000_0000}; // see [R17]
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come from the state register; irq gates status with the mask, exchange_tick comes from the timer.
  assign prdata = st_r.rdata;
  assign class_byte = st_r.cls;
  assign detail_byte = st_r.det;
  assign alarm_code = st_r.code;
  assign alarm_slot = st_r.slot;
  assign alarm_sub_code = st_r.sub;
  assign exchange_tick = tick;
  assign irq = |(st_r.ista & st_r.imask);

endmodule
`default_nettype wire

// ---- src/fault_status_pkg.sv ----
// Package for the link fault status encoder: register map, field layout,
// alarm codes and timing constants.
// Assumes a 32-bit APB slave on a 100 MHz clock.
package fault_status_pkg;

  // Register byte addresses.
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_ALARM = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;
  localparam logic [11:0] ADDR_CTRL = 12'h010;
  localparam logic [11:0] ADDR_SLOT = 12'h014;

  // Class byte bit positions.
  localparam int CLS_MASTER_BAD = 0;
  localparam int CLS_SLAVE_ERR = 1;
  localparam int CLS_LINK_DROP = 2;
  localparam int CLS_PARITY_A = 3;
  localparam int CLS_PARITY_B = 4;

  // Detail byte bit positions.
  localparam int DET_GROUP_LSB = 0;
  localparam int DET_GROUP_W = 5;
  localparam int DET_BAD_DATA = 5;
  localparam int DET_OTHER = 6;
  localparam int DET_WDOG_PAR = 7;

  // Alarm codes.
  localparam logic [9:0] ALM_NONE = 10'd0;
  localparam logic [9:0] ALM_LINK = 10'd950;
  localparam logic [9:0] ALM_WDOG = 10'd951;
  localparam logic [9:0] ALM_OPTION = 10'd972;
  localparam logic [9:0] ALM_FBUS = 10'd974;
  localparam logic [9:0] ALM_LOCAL = 10'd975;

  // Interrupt status bit positions.
  localparam int IRQ_LINK = 0;
  localparam int IRQ_WDOG = 1;
  localparam int IRQ_OPTION = 2;
  localparam int IRQ_FBUS = 3;
  localparam int IRQ_LOCAL = 4;
  localparam int IRQ_W = 5;

  // Link exchange period.
  localparam int CLK_MHZ = 100;
  localparam int LINK_PERIOD_NS = 2000;
  localparam int LINK_PERIOD_CYC = (LINK_PERIOD_NS * CLK_MHZ) / 1000;

  // Reset values.
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

  // Slave station fault kinds.
  typedef enum logic [1:0] {
    SLV_BAD_DATA,
    SLV_OTHER,
    SLV_WDOG,
    SLV_PARITY
  } slave_fault_t;

endpackage

// ---- src/link_exchange_timer.sv ----
// Fixed-interval strobe that paces the output and input exchanges.
// Assumes one clock domain; strobe is one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module link_exchange_timer #(
  parameter int PERIOD = 200
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous active-low reset.
  input wire logic run, // Counting enabled.
  output logic tick // One-cycle strobe each period.
);

  logic [15:0] cnt_r;

  // Counts down the period and strobes at zero.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (!run) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else if (cnt_r == 16'h0000) begin
      cnt_r <= 16'(PERIOD - 1);
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r - 16'h0001;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- tb/slave_station_model.sv ----
// Slave station model that answers the master at each exchange strobe.
// Assumes the bench sets cmd as {drop, err, kind[1:0], group[4:0]}.
`timescale 1ns/1ps
`default_nettype none
module slave_station_model
  import fault_status_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic tick, // Exchange strobe.
  input wire logic [8:0] cmd, // Fault to report.
  output logic slave_err, // Error flag.
  output logic [4:0] slave_group, // Faulting group.
  output fault_status_pkg::slave_fault_t slave_kind, // Fault kind.
  output logic link_drop // Link lost.
);
  // Reports change only at the strobe; an unused group field keeps moving.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {link_drop, slave_err, slave_group} <= 7'h00;
      slave_kind <= SLV_BAD_DATA;
    end else if (tick) begin
      link_drop <= cmd[8];
      slave_err <= cmd[7];
      slave_kind <= slave_fault_t'(cmd[6:5]);
      slave_group <= cmd[7] ? cmd[4:0] : ~slave_group;
    end
  end
endmodule
`default_nettype wire

// ---- tb/link_fault_chk.sv ----
// Checker for the link fault encoder status bytes and alarm codes.
// Assumes it is bound to the encoder top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module link_fault_chk
  import fault_status_pkg::*;
(
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset.
  input wire logic psel, // Select.
  input wire logic penable, // Enable.
  input wire logic pwrite, // Write.
  input wire logic [11:0] paddr, // Address.
  input wire logic [31:0] pwdata, // Data.
  input wire logic master_bad_data, // Fault.
  input wire logic slave_err, // Fault.
  input wire logic [4:0] slave_group, // Group.
  input wire fault_status_pkg::slave_fault_t slave_kind, // Kind.
  input wire logic link_drop, // Fault.
  input wire logic ctl_parity_err, // Fault.
  input wire logic ctl_wdog_err, // Fault.
  input wire logic exchange_tick, // Strobe.
  input wire logic [7:0] class_byte, // Class.
  input wire logic [7:0] detail_byte, // Detail.
  input wire logic [9:0] alarm_code, // Alarm.
  input wire logic irq // Interrupt.
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // A report is taken at a strobe only while no alarm is held.
  wire take = exchange_tick && alarm_code == ALM_NONE;
  wire ack = psel && penable && pwrite && paddr == ADDR_STATUS && pwdata[0];
  property p_mbad; take && master_bad_data |=> class_byte[0]; endproperty
  a_mbad: assert property (p_mbad) else $error("master flag lost");
  property p_serr; take && slave_err |=> class_byte[1]; endproperty
  a_serr: assert property (p_serr) else $error("slave flag lost");
  property p_grp;
    take && slave_err |=> detail_byte[4:0] == $past(slave_group) + 5'h01;
  endproperty
  a_grp: assert property (p_grp) else $error("group wrong");
  property p_wpar;
    take && slave_err |=>
      detail_byte[7] == ($past(slave_kind) inside {SLV_WDOG, SLV_PARITY});
  endproperty
  a_wpar: assert property (p_wpar) else $error("kind bit wrong");
  property p_drop; take && link_drop |=> class_byte[2]; endproperty
  a_drop: assert property (p_drop) else $error("drop flag lost");
  property p_par; take && ctl_parity_err |=> class_byte[3]; endproperty
  a_par: assert property (p_par) else $error("parity flag lost");
  property p_wdog;
    ctl_wdog_err && alarm_code == ALM_NONE |=> alarm_code == ALM_WDOG;
  endproperty
  a_wdog: assert property (p_wdog) else $error("wdog alarm lost");
  property p_hold; class_byte != 8'h00 && !ack |=> $stable(class_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("class moved");
  c_slave: cover property (take && slave_err);
  c_irq: cover property ($rose(irq));
  c_ack: cover property (ack && class_byte != 8'h00);
endmodule
bind link_fault_encoder link_fault_chk chk_u (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .master_bad_data, .slave_err, .slave_group, .slave_kind, .link_drop,
  .ctl_parity_err, .ctl_wdog_err, .exchange_tick, .class_byte,
  .detail_byte, .alarm_code, .irq);
`default_nettype wire

// ---- tb/testbench.sv ----
// Bench for the link fault encoder: random and corner fault reports.
// Assumes the exchange period is cut to 8 cycles for a short run.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fault_status_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, exchange_tick, slave_err;
  logic master_bad_data = 1'b0, ctl_parity_err = 1'b0, link_drop;
  logic [4:0] sys_err = 5'h00, slave_group;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'hEA850FA5;
  logic [3:0] option_slot = 4'h0, alarm_slot;
  logic [9:0] option_code = 10'h000, alarm_code, alarm_sub_code;
  logic [7:0] class_byte, detail_byte;
  logic [8:0] cmd = 9'h000;
  slave_fault_t slave_kind;
  logic [9:0] codes [5] = '{ALM_WDOG, ALM_OPTION, ALM_FBUS, ALM_FBUS,
    ALM_LOCAL};
  int bits [5] = '{IRQ_WDOG, IRQ_OPTION, IRQ_FBUS, IRQ_FBUS, IRQ_LOCAL};
  int fail_count = 0, samples_checked = 0, n;
  always #5 pclk = ~pclk;
  link_fault_encoder #(.PERIOD(8)) dut_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .master_bad_data, .slave_err, .slave_group,
    .slave_kind, .link_drop, .ctl_parity_err, .ctl_wdog_err(sys_err[0]),
    .option_err(sys_err[1]), .option_slot, .option_code,
    .fbus_opt_err(sys_err[2]), .fbus_ctl_err(sys_err[3]),
    .local_bus_err(sys_err[4]), .exchange_tick, .class_byte,
    .detail_byte, .alarm_code, .alarm_slot, .alarm_sub_code, .irq);
  slave_station_model st_u (.pclk, .presetn, .tick(exchange_tick), .cmd,
    .slave_err, .slave_group, .slave_kind, .link_drop);
  // Xorshift source with a fixed start.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected detail byte for a slave report.
  function automatic logic [7:0] exp_det(logic [8:0] c);
    return {c[6:5] >= 2'h2, c[6:5] == 2'h1, c[6:5] == 2'h0, c[4:0] + 5'h01};
  endfunction
  task automatic chk(input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  // One APB transfer; read data lands in q.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    chk(pslverr, 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Link fault report: slave via the model, master flags at the strobe.
  task automatic link(input logic [8:0] c, input logic mb, pe);
    logic any;
    any = |{pe, c[8:7], mb};
    @(posedge pclk);
    cmd <= c;
    @(posedge pclk iff exchange_tick);
    master_bad_data <= mb;
    ctl_parity_err <= pe;
    repeat (2) @(posedge pclk iff exchange_tick);
    #1;
    chk(class_byte, {4'h0, pe, c[8:7], mb});
    chk(detail_byte, c[7] ? exp_det(c) : 8'h00);
    chk(alarm_code, any ? ALM_LINK : ALM_NONE);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, {31'h0, any});
    cmd <= 9'h000;
    master_bad_data <= 1'b0;
    ctl_parity_err <= 1'b0;
    repeat (2) @(posedge pclk iff exchange_tick);
    chk(class_byte, {4'h0, pe, c[8:7], mb});
    apb(1'b1, ADDR_STATUS, 32'h1);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    chk(class_byte, 8'h00);
  endtask
  // System alarm pulse, then mask, read, clear and acknowledge.
  task automatic sys(input int i);
    q = rnd();
    @(posedge pclk);
    option_slot <= q[3:0];
    option_code <= q[13:4];
    sys_err <= 5'h01 << i;
    @(posedge pclk);
    sys_err <= 5'h00;
    repeat (2) @(posedge pclk);
    #1;
    chk(alarm_code, codes[i]);
    chk(irq, 1'b0);
    if (i == 1) chk({alarm_sub_code, alarm_slot},
                    {option_code, option_slot});
    apb(1'b1, ADDR_IRQ_MASK, 32'h1F);
    chk(irq, 1'b1);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk(q, 32'h1 << bits[i]);
    apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
    chk(irq, 1'b0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h1);
    chk(alarm_code, ALM_NONE);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence: reset values, strobe spacing, corners, random, alarms.
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({class_byte, detail_byte, irq}, 17'h0);
    apb(1'b0, ADDR_IRQ_MASK, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h1);
    apb(1'b0, 12'h018, 32'h0);
    chk(q, 32'h0);
    @(posedge pclk iff exchange_tick);
    n = 0;
    do begin @(posedge pclk); n++; end while (exchange_tick !== 1'b1);
    chk(n, 8);
    // Stopping the exchange timer must silence the strobe.
    apb(1'b1, ADDR_CTRL, 32'h0);
    repeat (2) @(posedge pclk);
    n = 0;
    repeat (24) @(posedge pclk) if (exchange_tick !== 1'b0) n++;
    chk(n, 0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(q, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h1);
    link(9'h1FF, 1'b1, 1'b1);
    link(9'h0C1, 1'b1, 1'b0);
    for (int k = 0; k < 16; k++) begin
      q = rnd();
      link(q[8:0], q[9], q[10]);
    end
    for (int k = 0; k < 5; k++) sys(k);
    wrap_up;
  end
  initial begin
    #300000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
